/* src/ris_consts.svh */
// Constants for the two-wire RTC slave access block
`ifndef RIS_CONSTS_SVH
`define RIS_CONSTS_SVH

`define RIS_SLAVE_ADDR   7'h32
`define RIS_LINK_IDLE    3'h6
`define RIS_PTR_STOP     4'hF
`define RIS_FMT_RD_A     4'h4
`define RIS_FMT_RD_B     4'h5
`define RIS_READ_IDLE    8'hFF
`define RIS_ACK_SLOT     4'h8
`define RIS_ACK_DONE     4'h9
`define RIS_CLK_NS       50
`define RIS_TIMEOUT_NS   500000000
`define RIS_TIMEOUT_CYC  (`RIS_TIMEOUT_NS / `RIS_CLK_NS)
`define RIS_CARRY_NS     61000
`define RIS_CARRY_CYC    (`RIS_CARRY_NS / `RIS_CLK_NS)

`endif

/* src/ris_pkg.sv */
// Types shared by the two-wire RTC slave access block
package ris_pkg;

    // Transfer phase, one-hot
    typedef enum logic [5:0] {
        PH_IDLE = 6'h01,
        PH_ADDR = 6'h02,
        PH_PTR  = 6'h04,
        PH_WR   = 6'h08,
        PH_RD   = 6'h10,
        PH_WAIT = 6'h20
    } ris_phase_t;

    // Register write request towards the register file
    typedef struct packed {
        logic       en;
        logic [3:0] addr;
        logic [7:0] data;
    } ris_wr_t;

endpackage : ris_pkg

/* src/ris_sync2.sv */
// Two-stage synchroniser for a group of levels
`timescale 1ns/1ps
module ris_sync2 #(
    parameter int               WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input  logic             clk,
    input  logic             rst,
    input  logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] meta;

    // First stage feeds only the second stage; reset to the idle level so no false edge follows
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meta <= RST_VAL;
            dout <= RST_VAL;
        end
        else
        begin
            meta <= din;
            dout <= meta;
        end
    end

endmodule : ris_sync2

/* src/ris_i2c_slave.sv */
// Two-wire slave access front end with carry hold and access watchdog
`timescale 1ns/1ps
`include "ris_consts.svh"
module ris_i2c_slave #(
    parameter int unsigned TIMEOUT_CYC = `RIS_TIMEOUT_CYC
) (
    input  logic           ref_clk,
    input  logic           rst,
    input  logic           linkClk,
    input  logic           linkRst,
    input  logic           sclIn,
    input  logic           sdaIn,
    output logic           sdaOut,
    output logic           sdaOe,
    output logic [3:0]     regRdAddr,
    input  logic [7:0]     regRdData,
    output ris_pkg::ris_wr_t regWr,
    input  logic           carryIn,
    output logic           carryOut,
    output logic           carryHold
);
    import ris_pkg::*;

    localparam int TW = $clog2(TIMEOUT_CYC + 1);

    // ---------------- Link domain ----------------
    logic [2:0]  linkSyn;
    logic        sclS;
    logic        sdaS;
    logic        toTglS;
    logic        sclPrev;
    logic        sdaPrev;
    logic        toTglPrev;
    ris_phase_t  phase;
    logic [3:0]  bitCnt;
    logic [7:0]  shift;
    logic [3:0]  ptr;
    logic        firstData;
    logic        lockout;
    logic        loadReq;
    logic        masterNak;
    logic        startTgl;
    logic        stopTgl;
    logic        toTgl;

    // Pins and the watchdog toggle enter through two flops
    ris_sync2 #(.WIDTH(3), .RST_VAL(`RIS_LINK_IDLE)) u_linkSync (
        .clk  (linkClk),
        .rst  (linkRst),
        .din  ({sclIn, sdaIn, toTgl}),
        .dout (linkSyn)
    );

    assign sclS   = linkSyn[2];
    assign sdaS   = linkSyn[1];
    assign toTglS = linkSyn[0];

    // Bus condition decoding on synchronised levels
    wire sclRise  = sclS & ~sclPrev;
    wire sclFall  = ~sclS & sclPrev;
    wire startDet = sclS & sclPrev & sdaPrev & ~sdaS;
    wire stopDet  = sclS & sclPrev & ~sdaPrev & sdaS;
    wire abortDet = toTglS ^ toTglPrev;
    wire ackWin   = sclFall && (bitCnt == `RIS_ACK_SLOT);
    wire byteDone = sclFall && (bitCnt == `RIS_ACK_DONE);
    wire addrHit  = (shift[7:1] == `RIS_SLAVE_ADDR);
    wire rwBit    = shift[0];
    wire ackAddr  = addrHit && !(lockout && !rwBit);
    wire fmtRead  = (shift[3:0] == `RIS_FMT_RD_A) || (shift[3:0] == `RIS_FMT_RD_B);
    wire [3:0] wrPtr = firstData ? ptr : 4'(ptr + 4'h1);
    wire evBusy   = abortDet | stopDet | startDet | loadReq;
    wire advance  = ackWin && !evBusy && (phase == PH_WR) && !lockout && !firstData;

    assign regRdAddr = ptr;

    // Edge history of the synchronised lines
    always_ff @(posedge linkClk)
    begin
        if (linkRst)
        begin
            sclPrev   <= 1'b1;
            sdaPrev   <= 1'b1;
            toTglPrev <= 1'b0;
        end
        else
        begin
            sclPrev   <= sclS;
            sdaPrev   <= sdaS;
            toTglPrev <= toTglS;
        end
    end

    // Byte engine: Stop and watchdog abort take priority over everything
    always_ff @(posedge linkClk)
    begin
        if (linkRst)
        begin
            phase     <= PH_IDLE;
            bitCnt    <= 4'h0;
            shift     <= 8'h00;
            ptr       <= `RIS_PTR_STOP;
            firstData <= 1'b0;
            lockout   <= 1'b0;
            loadReq   <= 1'b0;
            masterNak <= 1'b0;
            startTgl  <= 1'b0;
            stopTgl   <= 1'b0;
            sdaOe     <= 1'b0;
            sdaOut    <= 1'b0;
            regWr     <= '0;
        end
        else
        begin
            regWr.en <= 1'b0;
            if (abortDet || stopDet)
            begin
                phase   <= PH_IDLE;
                ptr     <= `RIS_PTR_STOP;
                sdaOe   <= 1'b0;
                loadReq <= 1'b0;
                lockout <= abortDet;
                if (stopDet)
                    stopTgl <= ~stopTgl;
            end
            else if (startDet)
            begin
                // Repeated Start re-enters address phase, pointer kept
                phase    <= PH_ADDR;
                bitCnt   <= 4'h0;
                sdaOe    <= 1'b0;
                startTgl <= ~startTgl;
            end
            else if (loadReq)
            begin
                // Pointer settled last cycle, so read data is valid now
                shift   <= lockout ? `RIS_READ_IDLE : regRdData;
                sdaOe   <= ~(lockout | regRdData[7]);
                bitCnt  <= 4'h0;
                loadReq <= 1'b0;
            end
            else if (sclRise)
            begin
                if (bitCnt < `RIS_ACK_SLOT)
                begin
                    if (phase != PH_RD)
                        shift <= {shift[6:0], sdaS};
                    bitCnt <= 4'(bitCnt + 4'h1);
                end
                else if (bitCnt == `RIS_ACK_SLOT)
                begin
                    masterNak <= sdaS;
                    bitCnt    <= `RIS_ACK_DONE;
                end
            end
            else if (ackWin)
            begin
                // Ninth clock: drive the acknowledge low or release
                case (phase)
                    PH_ADDR: sdaOe <= ackAddr;
                    PH_PTR:  sdaOe <= ~lockout;
                    PH_WR:
                    begin
                        sdaOe <= ~lockout;
                        if (!lockout)
                        begin
                            regWr     <= '{en: 1'b1, addr: wrPtr, data: shift};
                            ptr       <= wrPtr;
                            firstData <= 1'b0;
                        end
                    end
                    default: sdaOe <= 1'b0;
                endcase
            end
            else if (byteDone)
            begin
                sdaOe  <= 1'b0;
                bitCnt <= 4'h0;
                case (phase)
                    PH_ADDR:
                    begin
                        if (!addrHit)
                            phase <= PH_IDLE;
                        else if (rwBit)
                        begin
                            phase   <= PH_RD;
                            loadReq <= 1'b1;
                        end
                        else
                            phase <= PH_PTR;
                    end
                    PH_PTR:
                    begin
                        ptr       <= shift[7:4];
                        firstData <= 1'b1;
                        if (fmtRead)
                        begin
                            phase   <= PH_RD;
                            loadReq <= 1'b1;
                        end
                        else
                            phase <= PH_WR;
                    end
                    PH_RD:
                    begin
                        if (masterNak)
                            phase <= PH_WAIT;
                        else
                        begin
                            ptr     <= 4'(ptr + 4'h1);
                            loadReq <= 1'b1;
                        end
                    end
                    default: phase <= phase;
                endcase
            end
            else if (sclFall && phase == PH_RD && bitCnt != 4'h0)
            begin
                // Next data bit, open drain: enable means low
                sdaOe <= ~shift[6];
                shift <= {shift[6:0], 1'b1};
            end
        end
    end

    chk_addr_nak: assert property (@(posedge linkClk) disable iff (linkRst)
        (ackWin && !evBusy && phase == PH_ADDR && !addrHit) |=> !sdaOe)
        else $error("foreign address acknowledged");
    chk_addr_ack: assert property (@(posedge linkClk) disable iff (linkRst)
        (ackWin && !evBusy && phase == PH_ADDR && ackAddr) |=> sdaOe)
        else $error("own address not acknowledged");
    chk_stop_ptr: assert property (@(posedge linkClk) disable iff (linkRst)
        stopDet |=> (ptr == `RIS_PTR_STOP) && phase == PH_IDLE)
        else $error("pointer not forced after stop");
    chk_ptr_wrap: assert property (@(posedge linkClk) disable iff (linkRst)
        (advance && ptr == 4'hF) |=> (ptr == 4'h0) && regWr.en)
        else $error("pointer did not wrap");
    chk_wr_addr: assert property (@(posedge linkClk) disable iff (linkRst)
        regWr.en |-> (regWr.addr == ptr) && $past(phase) == PH_WR)
        else $error("write address differs from pointer");
    chk_first_data: assert property (@(posedge linkClk) disable iff (linkRst)
        (ackWin && !evBusy && phase == PH_WR && !lockout && firstData)
        |=> regWr.en && (regWr.addr == $past(ptr)) && (regWr.data == $past(shift)))
        else $error("first data byte not stored at pointer");
    chk_fmt_read: assert property (@(posedge linkClk) disable iff (linkRst)
        (byteDone && !evBusy && phase == PH_PTR && fmtRead) |=> (phase == PH_RD) && loadReq)
        else $error("read format did not start read");
    chk_abort_lock: assert property (@(posedge linkClk) disable iff (linkRst)
        abortDet |=> lockout && (phase == PH_IDLE) && (ptr == `RIS_PTR_STOP))
        else $error("watchdog abort not taken");
    chk_lock_ff: assert property (@(posedge linkClk) disable iff (linkRst)
        (loadReq && lockout && !abortDet && !stopDet && !startDet)
        |=> shift == `RIS_READ_IDLE)
        else $error("locked read not FFh");
    chk_nak_release: assert property (@(posedge linkClk) disable iff (linkRst)
        (phase == PH_WAIT) |-> !sdaOe)
        else $error("line driven after master nack");

    // ---------------- Reference clock domain ----------------
    logic [1:0]    refSyn;
    logic          startPrev;
    logic          stopPrev;
    logic          active;
    logic [TW-1:0] timer;
    logic          pend;

    // Start and Stop toggles cross from the link side
    ris_sync2 #(.WIDTH(2)) u_refSync (
        .clk  (ref_clk),
        .rst  (rst),
        .din  ({startTgl, stopTgl}),
        .dout (refSyn)
    );

    wire startEv    = refSyn[1] ^ startPrev;
    wire stopEv     = refSyn[0] ^ stopPrev;
    wire timeoutHit = active && (timer == TW'(TIMEOUT_CYC - 1));

    assign carryHold = active;

    // Access window and watchdog; a Start reloads the timer only while no access window is active
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            startPrev <= 1'b0;
            stopPrev  <= 1'b0;
            active    <= 1'b0;
            timer     <= '0;
            toTgl     <= 1'b0;
        end
        else
        begin
            startPrev <= refSyn[1];
            stopPrev  <= refSyn[0];
            if (stopEv || timeoutHit)
                active <= 1'b0;
            else if (startEv)
                active <= 1'b1;
            if (startEv && !active)
                timer <= '0;
            else if (active)
                timer <= TW'(timer + 1'b1);
            if (timeoutHit)
                toTgl <= ~toTgl;
        end
    end

    // Carry held while active; set wins over the release clear
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            pend     <= 1'b0;
            carryOut <= 1'b0;
        end
        else
        begin
            if (carryIn && active)
                pend <= 1'b1;
            else if (!active)
                pend <= 1'b0;
            carryOut <= !active && (carryIn || pend);
        end
    end

    chk_hold_start: assert property (@(posedge ref_clk) disable iff (rst)
        (startEv && !stopEv && !timeoutHit) |=> carryHold)
        else $error("carry hold not taken at start");
    chk_carry_free: assert property (@(posedge ref_clk) disable iff (rst)
        (carryIn && !active) |=> carryOut)
        else $error("idle carry not passed on");
    chk_carry_held: assert property (@(posedge ref_clk) disable iff (rst)
        active |=> !carryOut)
        else $error("carry leaked during access");
    chk_carry_apply: assert property (@(posedge ref_clk) disable iff (rst)
        ($fell(active) && pend) |=> carryOut && !pend)
        else $error("held carry not applied after stop");
    chk_timeout_end: assert property (@(posedge ref_clk) disable iff (rst)
        timeoutHit |=> !carryHold && (toTgl != $past(toTgl)))
        else $error("watchdog did not end access");
    chk_rstart_keep: assert property (@(posedge ref_clk) disable iff (rst)
        (active && startEv && !stopEv && !timeoutHit)
        |=> timer == TW'($past(timer) + 1'b1))
        else $error("repeated start restarted watchdog");

endmodule : ris_i2c_slave

/* testbench/ris_bus_master.sv */
// Behavioural two-wire bus master that drives the slave from the far side
`timescale 1ns/1ps
module ris_bus_master (
    input  wire logic linkClk,
    input  wire logic sdaLine,
    output logic      sclPull,
    output logic      sdaPull
);
    // Pull high means the line is held low; released lines float high on the pull-up
    initial sclPull = 1'b0;
    initial sdaPull = 1'b0;

    // Wait n link clock edges; all pin changes land just after an edge
    task automatic tick(input int n);
        repeat (n) @(posedge linkClk);
    endtask : tick

    // Start or repeated Start; SDA falls while SCL is high
    task automatic start();
        sdaPull <= 1'b0;
        tick(4);
        sclPull <= 1'b0;
        tick(8);
        sdaPull <= 1'b1;
        tick(8);
        sclPull <= 1'b1;
        tick(2);
    endtask : start

    // One bit: data set while SCL low, sampled at the end of the high phase
    task automatic bitx(input logic b, output logic s);
        sdaPull <= !b;
        tick(6);
        sclPull <= 1'b0;
        tick(8);
        s = sdaLine;
        sclPull <= 1'b1;
        tick(2);
    endtask : bitx

    // Byte out MSB first, then release SDA for the slave acknowledge
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bitx(d[i], s);
        bitx(1'b1, s);
        ack = !s;
    endtask : wbyte

    // Byte in; the final byte is not acknowledged so the slave lets go
    task automatic rbyte(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            bitx(1'b1, s);
            d[i] = s;
        end
        bitx(last, s);
    endtask : rbyte

    // Stop, then keep the bus quiet long enough for a held carry to land
    task automatic stop();
        sdaPull <= 1'b1;
        tick(6);
        sclPull <= 1'b0;
        tick(8);
        sdaPull <= 1'b0;
        tick(520);
    endtask : stop
endmodule : ris_bus_master

/* testbench/test_rtc_i2c_slave_access.sv */
// Self-checking bench for the two-wire RTC slave access block
`timescale 1ns/1ps
module test_rtc_i2c_slave_access;
    import ris_pkg::*;

    logic             ref_clk = 1'b0;
    logic             linkClk = 1'b0;
    logic             rst = 1'b1;
    logic             linkRst = 1'b1;
    logic             carryIn = 1'b0;
    logic             sclPull;
    logic             sdaPull;
    logic             sdaOut;
    logic             sdaOe;
    logic             carryOut;
    logic             carryHold;
    logic [3:0]       regRdAddr;
    ris_wr_t          regWr;
    logic [7:0]       mem [16];
    logic [7:0]       expMem [16];
    logic [7:0]       carryCnt = 8'h00;
    logic [7:0]       base;
    logic [7:0]       d;
    logic             ack;
    int               fails = 0;
    int               checks = 0;

    // Link clock offset so the two domains never share rising edges
    always #25 ref_clk = ~ref_clk;
    always #62.5 linkClk = ~linkClk;

    // Open-drain wire: low if either party pulls
    wire sclLine = !sclPull;
    wire sdaLine = !(sdaPull || (sdaOe && !sdaOut));

    ris_i2c_slave #(.TIMEOUT_CYC(2000)) u_dut (
        .ref_clk(ref_clk), .rst(rst), .linkClk(linkClk), .linkRst(linkRst),
        .sclIn(sclLine), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
        .regRdAddr(regRdAddr), .regRdData(mem[regRdAddr]), .regWr(regWr),
        .carryIn(carryIn), .carryOut(carryOut), .carryHold(carryHold)
    );

    ris_bus_master u_mst (.linkClk(linkClk), .sdaLine(sdaLine), .sclPull(sclPull), .sdaPull(sdaPull));

    // Register file stand-in and carry pulse counter
    always @(posedge linkClk) if (regWr.en === 1'b1) mem[regWr.addr] <= regWr.data;
    always @(posedge ref_clk) if (carryOut === 1'b1) carryCnt <= carryCnt + 8'h01;

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
        checks++;
        if (seen !== want)
        begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, want, seen);
        end
    endtask : check

    task automatic wrap_up();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : wrap_up

    task automatic pulse_carry();
        @(posedge ref_clk) carryIn <= 1'b1;
        @(posedge ref_clk) carryIn <= 1'b0;
    endtask : pulse_carry

    // Address, pointer byte with write format, three data bytes across the wrap
    task automatic test_write();
        u_mst.start();
        u_mst.wbyte(8'h64, ack);
        check("addr ack", {7'h0, ack}, 8'h01);
        u_mst.wbyte(8'hE0, ack);
        check("ptr ack", {7'h0, ack}, 8'h01);
        for (int i = 0; i < 3; i++)
        begin
            u_mst.wbyte(8'hA1 + 8'(i) * 8'h11, ack);
            check("data ack", {7'h0, ack}, 8'h01);
            expMem[4'hE + 4'(i)] = 8'hA1 + 8'(i) * 8'h11;
        end
        u_mst.stop();
        for (int i = 0; i < 16; i++) check("reg", mem[i], expMem[i]);
        check("ptr after stop", {4'h0, regRdAddr}, 8'h0F);
        $display("test write done");
    endtask : test_write

    // Read right after the address from the post-Stop pointer
    task automatic test_plain_read();
        u_mst.start();
        u_mst.wbyte(8'h65, ack);
        check("read addr ack", {7'h0, ack}, 8'h01);
        u_mst.rbyte(1'b0, d);
        check("read F", d, expMem[15]);
        u_mst.rbyte(1'b1, d);
        check("read wrap", d, expMem[0]);
        u_mst.stop();
        $display("test plain read done");
    endtask : test_plain_read

    // Pointer write then repeated Start into read
    task automatic test_rs_read();
        u_mst.start();
        u_mst.wbyte(8'h64, ack);
        u_mst.wbyte(8'h20, ack);
        u_mst.start();
        u_mst.wbyte(8'h65, ack);
        check("rs addr ack", {7'h0, ack}, 8'h01);
        u_mst.rbyte(1'b0, d);
        check("rs read 2", d, expMem[2]);
        u_mst.rbyte(1'b1, d);
        check("rs read 3", d, expMem[3]);
        u_mst.stop();
        $display("test repeated start read done");
    endtask : test_rs_read

    // Formats 4h and 5h stream data straight after the pointer byte
    task automatic test_fmt_read();
        for (int f = 4; f <= 5; f++)
        begin
            u_mst.start();
            u_mst.wbyte(8'h64, ack);
            u_mst.wbyte({4'hF, 4'(f)}, ack);
            u_mst.rbyte(1'b0, d);
            check("fmt read F", d, expMem[15]);
            u_mst.rbyte(1'b1, d);
            check("fmt read 0", d, expMem[0]);
            u_mst.stop();
        end
        $display("test format read done");
    endtask : test_fmt_read

    // Another slave's address is not answered, nor are its bytes
    task automatic test_other_addr();
        u_mst.start();
        u_mst.wbyte(8'h66, ack);
        check("other addr ack", {7'h0, ack}, 8'h00);
        u_mst.wbyte(8'h00, ack);
        check("other byte ack", {7'h0, ack}, 8'h00);
        u_mst.stop();
        for (int i = 0; i < 16; i++) check("reg kept", mem[i], expMem[i]);
        $display("test other address done");
    endtask : test_other_addr

    // Carry passes at once when idle, is held during an access, lands after Stop
    task automatic test_carry();
        base = carryCnt;
        pulse_carry();
        repeat (3) @(posedge ref_clk);
        check("free carry", carryCnt - base, 8'h01);
        u_mst.start();
        u_mst.wbyte(8'h64, ack);
        check("hold", {7'h0, carryHold}, 8'h01);
        base = carryCnt;
        pulse_carry();
        repeat (20) @(posedge ref_clk);
        check("held carry", carryCnt - base, 8'h00);
        u_mst.stop();
        check("late carry", carryCnt - base, 8'h01);
        check("hold off", {7'h0, carryHold}, 8'h00);
        $display("test carry done");
    endtask : test_carry

    // Watchdog counts from the first Start, then locks writes out and reads FFh
    task automatic test_timeout();
        u_mst.start();
        u_mst.wbyte(8'h64, ack);
        u_mst.tick(300);
        u_mst.start();
        u_mst.wbyte(8'h64, ack);
        check("rs ack", {7'h0, ack}, 8'h01);
        u_mst.tick(300);
        check("hold released", {7'h0, carryHold}, 8'h00);
        u_mst.wbyte(8'h00, ack);
        check("locked write", {7'h0, ack}, 8'h00);
        u_mst.start();
        u_mst.wbyte(8'h64, ack);
        check("locked addr", {7'h0, ack}, 8'h00);
        u_mst.start();
        u_mst.wbyte(8'h65, ack);
        u_mst.rbyte(1'b1, d);
        check("locked read", d, 8'hFF);
        u_mst.stop();
        $display("test timeout done");
    endtask : test_timeout

    // Hang guard
    initial
    begin
        repeat (100000) @(posedge ref_clk);
        fails++;
        wrap_up();
    end

    initial
    begin
        for (int i = 0; i < 16; i++)
        begin
            mem[i] = 8'h30 + 8'(i);
            expMem[i] = 8'h30 + 8'(i);
        end
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge linkClk) linkRst <= 1'b0;
        repeat (4) @(posedge linkClk);
        test_write();
        test_plain_read();
        test_rs_read();
        test_fmt_read();
        test_other_addr();
        test_carry();
        test_timeout();
        wrap_up();
    end
endmodule : test_rtc_i2c_slave_access
